// [bench/command_report_interrupt_codes_test.sv]
// self-checking bench for crrep_core: command checks and report codes
// assumes crrep_peer stands in for the sequencer and the far bus party
`timescale 1ns/1ns
module command_report_interrupt_codes_test;
    import crrep_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cv = 1'b0, up = 1'b0, cz = 1'b0, lz = 1'b0, asm = 1'b0, ar = 1'b0;
    logic rt = 1'b0, nx = 1'b1, rb = 1'b0, ta = 1'b0, pd = 1'b0, le = 1'b0, dd = 1'b0, dp = 1'b0;
    logic bf = 1'b0, rq = 1'b0, rd = 1'b0, acc, busy, vld, ed, atn, ack, lp, mr;
    logic [7:0] cc = 8'h00, ml = 8'h00, dly = 8'h14, code;
    logic [2:0] cg = 3'h0;
    logic [1:0] am = 2'h0;
    int error_cnt = 0, n_checks = 0;
    always #5 clk = ~clk;
    crrep_core dut_u (.ref_clk_in(clk), .sys_rst_in(rst), .cmd_valid_in(cv), .cmd_code_in(cc),
        .cmd_from_user_prog_in(up), .ext_msg_len_in(ml), .cdb_group_in(cg), .cdb_len_zero_in(lz),
        .count_zero_in(cz), .auto_sel_resp_mode_in(asm), .auto_receive_in(ar), .role_target_in(rt),
        .nexus_in(nx), .rx_buf_occupied_in(rb), .transfer_active_in(ta), .exec_done_in(ed),
        .pause_done_in(pd), .long_ext_msg_in(le), .diag_done_in(dd), .diag_pass_in(dp), .atn_in(atn),
        .ack_in(ack), .last_phase_in(lp), .msg_received_in(mr), .bus_free_in(bf), .req_in(rq),
        .report_read_in(rd), .cmd_accept_out(acc), .busy_out(busy), .report_valid_out(vld),
        .report_code_out(code));
    crrep_peer peer_u (.clk_in(clk), .start_in(acc), .run_in(busy), .delay_in(dly), .atn_mode_in(am),
        .done_out(ed), .atn_out(atn), .ack_out(ack), .last_out(lp), .msg_out(mr));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk8(input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk8
    task automatic chk1(input logic e, input logic g);
        chk8({7'h00, e}, {7'h00, g});
    endtask : chk1
    task automatic issue(input logic [7:0] c);
        @(posedge clk);
        cv <= 1'b1;
        cc <= c;
        @(posedge clk);
        cv <= 1'b0;
    endtask : issue
    // waits for a code, checks it holds, reads it and sees the holder empty
    task automatic report(input logic [7:0] e);
        int k;
        k = 0;
        #1;
        while (vld !== 1'b1 && k < 200) begin
            @(posedge clk);
            #1;
            k++;
        end
        // a report that never comes must not pass on a stale code
        chk1(1'b1, vld);
        chk8(e, code);
        repeat (2) @(posedge clk);
        #1;
        chk8(e, code);
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk1(1'b0, vld);
        @(posedge clk);
    endtask : report
    task automatic inv(input logic [7:0] c);
        issue(c);
        report(CODE_INVALID);
    endtask : inv
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_send;
        asm <= 1'b1;
        issue(CMD_PAUSE);
        report(CODE_REJECT);
        asm <= 1'b0;
        ml <= 8'h21;
        issue(CMD_SEND_MESSAGE_COMMAND);
        report(CODE_REJECT);
        ml <= 8'h20;
        issue(CMD_SEND_MESSAGE_COMMAND);
        #1;
        chk1(1'b1, acc);
        issue(CMD_SELF_DIAG);
        report(CODE_REJECT);
        report(CODE_DONE);
    endtask : t_send
    task automatic t_invalid;
        rt <= 1'b1;
        inv(CMD_SELECT);
        rt <= 1'b0;
        inv(CMD_RESELECT);
        up <= 1'b1;
        inv(CMD_SEQUENTIAL);
        up <= 1'b0;
        inv(8'hff);
        cz <= 1'b1;
        inv(CMD_XFER_INIT);
        cz <= 1'b0;
        cg <= CDB_GROUP6;
        lz <= 1'b1;
        inv(CMD_SEND_CDB);
        lz <= 1'b0;
        cg <= CDB_GROUP4;
        inv(CMD_SEND_CDB);
        cg <= 3'h0;
        nx <= 1'b0;
        inv(CMD_XFER_INIT);
        nx <= 1'b1;
        inv(CMD_SELECT);
        rb <= 1'b1;
        issue(CMD_RECV_MSG);
        report(CODE_RX_BUSY);
        issue(CMD_USER_PROG);
        report(CODE_RX_BUSY);
        rb <= 1'b0;
    endtask : t_invalid
    task automatic t_done;
        logic [7:0] exp [3] = '{CODE_DONE_ATN, CODE_DONE, CODE_DONE_ATN_MSG};
        for (int i = 0; i < 3; i++) begin
            am <= (i == 1) ? 2'h2 : 2'h1;
            ar <= (i == 2);
            issue(CMD_XFER_INIT);
            report(exp[i]);
        end
        am <= 2'h0;
        ar <= 1'b0;
    endtask : t_done
    task automatic t_pause;
        issue(CMD_PAUSE);
        report(CODE_PAUSE);
        dly <= 8'h3c;
        issue(CMD_SEND_MESSAGE_COMMAND);
        issue(CMD_PAUSE);
        #1;
        chk1(1'b1, acc);
        @(posedge clk);
        pd <= 1'b1;
        @(posedge clk);
        pd <= 1'b0;
        report(CODE_PAUSE);
        issue(CMD_SEND_MESSAGE_COMMAND);
        le <= 1'b1;
        @(posedge clk);
        le <= 1'b0;
        report(CODE_PAUSE);
        dly <= 8'h14;
    endtask : t_pause
    task automatic t_diag;
        for (int p = 1; p >= 0; p--) begin
            issue(CMD_SELF_DIAG);
            #1;
            chk1(1'b1, busy);
            issue(CMD_PAUSE);
            report(CODE_REJECT);
            @(posedge clk);
            dd <= 1'b1;
            dp <= p[0];
            @(posedge clk);
            dd <= 1'b0;
            report((p == 1) ? CODE_DIAG_GOOD : CODE_DIAG_BAD);
        end
    endtask : t_diag
    task automatic t_events;
        bf <= 1'b1;
        @(posedge clk);
        bf <= 1'b0;
        report(CODE_DISCONNECT);
        ta <= 1'b1;
        bf <= 1'b1;
        repeat (4) @(posedge clk);
        bf <= 1'b0;
        ta <= 1'b0;
        #1;
        chk1(1'b0, vld);
        @(posedge clk);
        rq <= 1'b1;
        report(CODE_REQ);
        rq <= 1'b0;
    endtask : t_events
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk8(CODE_RESET, code);
        @(posedge clk);
        t_send();
        t_invalid();
        t_done();
        t_pause();
        t_diag();
        t_events();
        close_out();
    end
    // the whole run needs well under 2000 cycles
    initial begin
        #50000;
        error_cnt++;
        close_out();
    end
endmodule : command_report_interrupt_codes_test

// [bench/crrep_peer.sv]
// far side stand-in: sequencer completion and the bus party's ATN/ACK
// assumes start_in is the accept pulse and run_in the busy flag of the block
`timescale 1ns/1ns
module crrep_peer (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic run_in,
    input wire logic [7:0] delay_in,
    input wire logic [1:0] atn_mode_in,
    output logic done_out,
    output logic atn_out,
    output logic ack_out,
    output logic last_out,
    output logic msg_out
);
    int cnt = 0;
    int tail = 0;
    logic done_q = 1'b0;
    logic msg_q = 1'b0;
    // count clears to zero when the block drops busy, as an aborted sequencer would
    always @(posedge clk_in) begin
        done_q <= 1'b0;
        msg_q <= 1'b0;
        if (start_in) begin
            cnt <= int'(delay_in);
        end else if (!run_in) begin
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            done_q <= 1'b1;
            tail <= 3;
        end
        if (tail > 1) begin
            tail <= tail - 1;
        end else if (tail == 1) begin
            tail <= 0;
            msg_q <= (atn_mode_in != 2'h0);
        end
    end
    assign done_out = done_q;
    assign msg_out = msg_q;
    // released bus lines sit deasserted through the terminators
    assign atn_out = (atn_mode_in != 2'h0) && (cnt != 0 || done_q);
    assign last_out = (cnt == 1) || done_q;
    assign ack_out = (atn_mode_in == 2'h2) && last_out;
endmodule : crrep_peer

// [design/crrep_core.sv]
// command check and report code generator for the protocol_controller
// assumes the sequencer starts on cmd_accept_out and returns done pulses;
// all inputs are synchronous to ref_clk_in
`timescale 1ns/1ns
module crrep_core (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic cmd_from_user_prog_in,
    input wire logic [7:0] ext_msg_len_in,
    input wire logic [2:0] cdb_group_in,
    input wire logic cdb_len_zero_in,
    input wire logic count_zero_in,
    input wire logic auto_sel_resp_mode_in,
    input wire logic auto_receive_in,
    input wire logic role_target_in,
    input wire logic nexus_in,
    input wire logic rx_buf_occupied_in,
    input wire logic transfer_active_in,
    input wire logic exec_done_in,
    input wire logic pause_done_in,
    input wire logic long_ext_msg_in,
    input wire logic diag_done_in,
    input wire logic diag_pass_in,
    input wire logic atn_in,
    input wire logic ack_in,
    input wire logic last_phase_in,
    input wire logic msg_received_in,
    input wire logic bus_free_in,
    input wire logic req_in,
    input wire logic report_read_in,
    output logic cmd_accept_out,
    output logic busy_out,
    output logic report_valid_out,
    output logic [7:0] report_code_out
);
    import crrep_pkg::*;

    typedef struct packed {
        crrep_state_t st;
        logic atn_ack;
        logic req_prev;
        logic bf_prev;
        logic accept;
        logic valid;
        logic [7:0] code;
    } crrep_regs_t;

    crrep_regs_t r_q;
    crrep_regs_t r_d;
    crrep_attr_t attr;
    logic can_post;
    logic busy;
    logic atn_seen;

    assign attr = crrep_decode(cmd_code_in);
    // a report may only be loaded into an empty holder or one being read
    assign can_post = !r_q.valid || report_read_in; // RQ24
    assign busy = (r_q.st != ST_IDLE);
    // attention counts only if it did not come together with ACK in the last phase in an earlier cycle
    assign atn_seen = atn_in && !r_q.atn_ack; // RQ20

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic post;
        logic [7:0] pcode;
        post = 1'b0;
        pcode = CODE_RESET;
        r_d = r_q;
        r_d.accept = 1'b0;
        r_d.req_prev = req_in;
        r_d.bf_prev = bus_free_in;
        if (report_read_in) begin
            r_d.valid = 1'b0; // RQ24
        end
        if (r_q.st == ST_EXEC && atn_in && ack_in && last_phase_in) begin
            r_d.atn_ack = 1'b1; // RQ20
        end
        case (r_q.st)
            ST_EXEC: begin
                if (long_ext_msg_in) begin
                    post = 1'b1;
                    pcode = CODE_PAUSE; // RQ14
                    r_d.st = ST_IDLE;
                end else if (exec_done_in) begin
                    r_d.st = ST_IDLE;
                    post = 1'b1;
                    if (!atn_seen) begin
                        pcode = CODE_DONE; // RQ1
                    end else if (!auto_receive_in) begin
                        pcode = CODE_DONE_ATN; // RQ19 RQ22
                    end else begin
                        post = 1'b0;
                        r_d.st = ST_ATN_MSG;
                    end
                end
            end
            ST_ATN_MSG: begin
                if (msg_received_in) begin
                    post = 1'b1;
                    pcode = CODE_DONE_ATN_MSG; // RQ21 RQ23
                    r_d.st = ST_IDLE;
                end
            end
            ST_PAUSING: begin
                if (pause_done_in) begin
                    post = 1'b1;
                    pcode = CODE_PAUSE; // RQ13
                    r_d.st = ST_IDLE;
                end
            end
            ST_DIAG: begin
                if (diag_done_in) begin
                    post = 1'b1;
                    pcode = diag_pass_in ? CODE_DIAG_GOOD : CODE_DIAG_BAD; // RQ15
                    r_d.st = ST_IDLE;
                end
            end
            default: begin
                if (bus_free_in && !r_q.bf_prev && nexus_in && !role_target_in && !transfer_active_in) begin
                    post = 1'b1;
                    pcode = CODE_DISCONNECT; // RQ17
                end else if (req_in && !r_q.req_prev && nexus_in && !role_target_in && !cmd_valid_in) begin
                    post = 1'b1;
                    pcode = CODE_REQ; // RQ18
                end
            end
        endcase
        // command checks; a command outranks a same-cycle idle event report
        if (cmd_valid_in) begin
            post = 1'b1;
            if (busy && !(attr.is_pause && r_q.st == ST_EXEC)) begin
                pcode = CODE_REJECT; // RQ3
                if (r_d.st == ST_IDLE) begin
                    post = 1'b0; // completion of the runner in this cycle loses its report along with the reject
                end
            end else if (busy) begin
                post = 1'b0;
                r_d.st = ST_PAUSING;
                r_d.accept = 1'b1;
            end else if (auto_sel_resp_mode_in) begin
                pcode = CODE_REJECT; // RQ2
            end else if (attr.is_send_message_command && ext_msg_len_in >= EXT_MSG_LIMIT) begin
                pcode = CODE_REJECT; // RQ4
            end else if (attr.is_seq && cmd_from_user_prog_in) begin
                pcode = CODE_INVALID; // RQ6
            end else if (!attr.defined || attr.is_seq) begin
                pcode = CODE_INVALID; // RQ7
            end else if ((attr.role == ROLE_TGT && !role_target_in) || (attr.role == ROLE_INIT && role_target_in)) begin
                pcode = CODE_INVALID; // RQ5
            end else if (attr.needs_cnt && count_zero_in) begin
                pcode = CODE_INVALID; // RQ8
            end else if (attr.is_cdb && (cdb_group_in == CDB_GROUP6 || cdb_group_in == CDB_GROUP7)
                         && cdb_len_zero_in) begin
                pcode = CODE_INVALID; // RQ9
            end else if (attr.is_cdb && (cdb_group_in == CDB_GROUP3 || cdb_group_in == CDB_GROUP4)) begin
                pcode = CODE_INVALID; // RQ10
            end else if (attr.starts_xfer && !nexus_in) begin
                pcode = CODE_INVALID; // RQ11
            end else if (attr.starts_sel && nexus_in) begin
                pcode = CODE_INVALID; // RQ12
            end else if (attr.is_recv && rx_buf_occupied_in) begin
                pcode = CODE_RX_BUSY; // RQ16
            end else if (attr.is_pause) begin
                pcode = CODE_PAUSE; // RQ13
            end else begin
                post = 1'b0;
                r_d.accept = 1'b1;
                r_d.atn_ack = 1'b0;
                r_d.st = attr.is_diag ? ST_DIAG : ST_EXEC;
            end
        end
        // a full holder drops the new report; the host must read first
        if (post && can_post) begin
            r_d.valid = 1'b1;
            r_d.code = pcode;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            r_q <= '{st: ST_IDLE, code: CODE_RESET, default: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    assign cmd_accept_out = r_q.accept;
    assign busy_out = busy;
    assign report_valid_out = r_q.valid;
    assign report_code_out = r_q.code;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence new_cmd_idle_s;
        cmd_valid_in && !busy_out && can_post;
    endsequence

    report_hold_a: assert property (report_valid_out && !report_read_in |=> report_valid_out && $stable(report_code_out)) // RQ24
        else $error("report changed before it was read");
    busy_reject_a: assert property (cmd_valid_in && r_q.st == ST_DIAG && !diag_done_in && can_post
        |=> report_valid_out && report_code_out == CODE_REJECT && !cmd_accept_out) // RQ3
        else $error("command during execution not rejected");
    auto_reject_a: assert property (new_cmd_idle_s and auto_sel_resp_mode_in |=> report_code_out == CODE_REJECT) // RQ2
        else $error("command in auto response mode not rejected");
    undef_cmd_a: assert property (new_cmd_idle_s and !auto_sel_resp_mode_in && !attr.defined
        |=> report_code_out == CODE_INVALID) // RQ7
        else $error("undefined command not reported invalid");
    long_send_a: assert property (new_cmd_idle_s and !auto_sel_resp_mode_in && cmd_code_in == CMD_SEND_MESSAGE_COMMAND
        && ext_msg_len_in > 8'h20 |=> report_code_out == CODE_REJECT) // RQ4
        else $error("long send message not rejected");
    clean_done_a: assert property (r_q.st == ST_EXEC && exec_done_in && !long_ext_msg_in && !atn_in && !cmd_valid_in
        && can_post |=> report_valid_out && report_code_out == CODE_DONE && !busy_out) // RQ1
        else $error("clean completion not reported");
    diag_result_a: assert property (r_q.st == ST_DIAG && diag_done_in && !cmd_valid_in && can_post
        |=> report_code_out == (($past(diag_pass_in)) ? CODE_DIAG_GOOD : CODE_DIAG_BAD)) // RQ15
        else $error("self diagnosis result wrong");
    atn_msg_a: assert property (r_q.st == ST_ATN_MSG && msg_received_in && can_post && !cmd_valid_in
        |=> report_valid_out && report_code_out == CODE_DONE_ATN_MSG && !busy_out) // RQ21
        else $error("attention message completion missing");
    disconnect_a: assert property (!busy_out && bus_free_in && !$past(bus_free_in) && nexus_in && !role_target_in
        && !transfer_active_in && !cmd_valid_in && can_post |=> report_code_out == CODE_DISCONNECT) // RQ17
        else $error("bus free during nexus not reported");
endmodule : crrep_core

// [include/crrep_pkg.sv]
// command report codes: constants, command encodings and attribute decode
// assumes a sequencer outside decodes nothing; this table is the only decoder
//
// How it works
// RQ1: clean completion reports code 60h
// RQ2: auto response mode rejects commands, 64h
// RQ3: command while busy rejected, runner untouched, except pause during execution, which is accepted; no reject is posted if the runner ends that cycle
// RQ4: send message over 32 bytes rejected
// RQ5: wrong role command reported invalid, 65h
// RQ6: sequential command in user program invalid
// RQ7: undefined command code reported invalid
// RQ8: zero count register for counted command invalid
// RQ9: zero length group 6/7 CDB invalid
// RQ10: group 3/4 CDB reported invalid
// RQ11: transfer command without nexus invalid
// RQ12: selection command during nexus invalid
// RQ13: finished pause reports code 67h
// RQ14: long incoming extended message pauses, 67h
// RQ15: self diagnosis pass 68h, fail 69h
// RQ16: receive while buffer occupied refused, 6Ch
// RQ17: initiator bus free outside transfer, 70h
// RQ18: target REQ with no command, 71h
// RQ19: completion with attention reports 61h
// RQ20: attention with ACK in last phase ignored; the code counts it when it first comes in the completion cycle
// RQ21: completion then attention message reports 62h
// RQ22: code 61h only without auto receive
// RQ23: code 62h only with auto receive
// RQ24: code held until host reads it
package crrep_pkg;
    // ------------------------------------------------------------
    // report codes
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_DONE = 8'h60;
    localparam logic [7:0] CODE_DONE_ATN = 8'h61;
    localparam logic [7:0] CODE_DONE_ATN_MSG = 8'h62;
    localparam logic [7:0] CODE_REJECT = 8'h64;
    localparam logic [7:0] CODE_INVALID = 8'h65;
    localparam logic [7:0] CODE_PAUSE = 8'h67;
    localparam logic [7:0] CODE_DIAG_GOOD = 8'h68;
    localparam logic [7:0] CODE_DIAG_BAD = 8'h69;
    localparam logic [7:0] CODE_RX_BUSY = 8'h6c;
    localparam logic [7:0] CODE_DISCONNECT = 8'h70;
    localparam logic [7:0] CODE_REQ = 8'h71;
    localparam logic [7:0] CODE_RESET = 8'h00;
    // ------------------------------------------------------------
    // command encodings and limits
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_SELECT = 8'h01;
    localparam logic [7:0] CMD_RESELECT = 8'h02;
    localparam logic [7:0] CMD_XFER_INIT = 8'h10;
    localparam logic [7:0] CMD_XFER_TGT = 8'h11;
    localparam logic [7:0] CMD_SEND_MESSAGE_COMMAND = 8'h20;
    localparam logic [7:0] CMD_RECV_MSG = 8'h21;
    localparam logic [7:0] CMD_RECV_CMD = 8'h22;
    localparam logic [7:0] CMD_RECV_STATUS = 8'h23;
    localparam logic [7:0] CMD_SEND_CDB = 8'h24;
    localparam logic [7:0] CMD_PAUSE = 8'h30;
    localparam logic [7:0] CMD_SELF_DIAG = 8'h31;
    localparam logic [7:0] CMD_USER_PROG = 8'h32;
    localparam logic [7:0] CMD_SEQUENTIAL = 8'h40;
    localparam logic [7:0] EXT_MSG_LIMIT = 8'h21;
    localparam logic [2:0] CDB_GROUP3 = 3'h3;
    localparam logic [2:0] CDB_GROUP4 = 3'h4;
    localparam logic [2:0] CDB_GROUP6 = 3'h6;
    localparam logic [2:0] CDB_GROUP7 = 3'h7;
    localparam logic [1:0] ROLE_ANY = 2'h0;
    localparam logic [1:0] ROLE_INIT = 2'h1;
    localparam logic [1:0] ROLE_TGT = 2'h2;

    typedef enum {ST_IDLE, ST_EXEC, ST_PAUSING, ST_DIAG, ST_ATN_MSG} crrep_state_t;

    typedef struct packed {
        logic defined;
        logic [1:0] role;
        logic needs_cnt;
        logic starts_xfer;
        logic starts_sel;
        logic is_recv;
        logic is_send_message_command;
        logic is_cdb;
        logic is_seq;
        logic is_pause;
        logic is_diag;
    } crrep_attr_t;

    function automatic crrep_attr_t crrep_decode(input logic [7:0] code);
        crrep_attr_t a;
        a = '0;
        a.defined = 1'b1;
        case (code)
            CMD_SELECT: begin a.role = ROLE_INIT; a.starts_sel = 1'b1; end
            CMD_RESELECT: begin a.role = ROLE_TGT; a.starts_sel = 1'b1; end
            CMD_XFER_INIT: begin a.role = ROLE_INIT; a.needs_cnt = 1'b1; a.starts_xfer = 1'b1; end
            CMD_XFER_TGT: begin a.role = ROLE_TGT; a.needs_cnt = 1'b1; a.starts_xfer = 1'b1; end
            CMD_SEND_MESSAGE_COMMAND: begin a.starts_xfer = 1'b1; a.is_send_message_command = 1'b1; end
            CMD_RECV_MSG: begin a.starts_xfer = 1'b1; a.is_recv = 1'b1; end
            CMD_RECV_CMD: begin a.role = ROLE_TGT; a.starts_xfer = 1'b1; a.is_recv = 1'b1; end
            CMD_RECV_STATUS: begin a.role = ROLE_INIT; a.starts_xfer = 1'b1; a.is_recv = 1'b1; end
            CMD_SEND_CDB: begin a.role = ROLE_INIT; a.starts_xfer = 1'b1; a.is_cdb = 1'b1; end
            CMD_PAUSE: a.is_pause = 1'b1;
            CMD_SELF_DIAG: a.is_diag = 1'b1;
            CMD_USER_PROG: a.is_recv = 1'b1;
            CMD_SEQUENTIAL: a.is_seq = 1'b1;
            default: a.defined = 1'b0;
        endcase
        return a;
    endfunction : crrep_decode
endpackage : crrep_pkg
